// File: hw/act_map.svh
// register offsets, field positions, reset values and timing counts of the converter timing
`ifndef ACT_MAP_SVH
`define ACT_MAP_SVH
// byte offsets on the register bus
`define ACT_OFS_CTRL 8'h00
`define ACT_OFS_STAT 8'h04
`define ACT_OFS_RESULT 8'h08
`define ACT_OFS_ISTAT 8'h0C
`define ACT_OFS_IMASK 8'h10
`define ACT_OFS_SYSCFG 8'h14
// reset values and writable bits
`define ACT_CTRL_RST 16'h0004
`define ACT_CTRL_WMASK 16'hFF0E
`define ACT_IMASK_RST 2'h0
`define ACT_SYSCFG_RST 1'h0
// interrupt status bit positions
`define ACT_IRQ_DONE 0
`define ACT_IRQ_CAL 1
// basic clock divisor per divider code
`define ACT_DIV_C0 5'h04
`define ACT_DIV_C1 5'h02
`define ACT_DIV_C2 5'h10
`define ACT_DIV_C3 5'h08
// sample length in basic periods per sample code
`define ACT_SMP_C0 7'h08
`define ACT_SMP_C1 7'h10
`define ACT_SMP_C2 7'h20
`define ACT_SMP_C3 7'h40
// decision and load timing, decision bit range and saturation results
`define ACT_BIT_BC 7'h04
`define ACT_POSTCAL_BC 7'h0C
`define ACT_LOAD_SYS 7'h06
`define ACT_CONV10P_BC 7'h34
`define ACT_CONV10_BC 7'h28
`define ACT_CONV8P_BC 7'h2C
`define ACT_CONV8_BC 7'h20
`define ACT_TOP_BIT 4'h9
`define ACT_LSB_10 4'h0
`define ACT_LSB_8 4'h2
`define ACT_RES_LOW 10'h000
`define ACT_RES_HIGH10 10'h3FF
`define ACT_RES_HIGH8 10'h0FF
// reset calibration bounds in basic periods
`define ACT_CAL_MIN_BC 14'h01E4
`define ACT_CAL_MAX_BC 14'h2DB0
`endif

// File: hw/act_pkg.sv
// types shared by the converter timing modules
package act_pkg;
    // one-hot conversion sequencer states
    typedef enum logic [4:0] {
        st_idle = 5'h01,
        st_sample = 5'h02,
        st_decide = 5'h04,
        st_postcal = 5'h08,
        st_load = 5'h10
    } act_fsm_t;
    // control register layout
    typedef struct packed {
        logic [1:0] clk_div;
        logic [1:0] smp_len;
        logic [3:0] imp_div;
        logic [3:0] rsv;
        logic improved;
        logic postcal;
        logic eight;
        logic start;
    } act_ctrl_t;
    // analog front end pins
    typedef struct packed {
        logic quiet;
        logic below;
        logic above;
        logic [9:0] level;
    } act_ain_t;
    // state of the top module held in its main state register, apart from the checker counters
    typedef struct packed {
        act_ctrl_t ctrl;
        logic halve;
        logic sys_ph;
        act_fsm_t fsm;
        logic [6:0] cnt;
        logic [3:0] bitn;
        logic [9:0] sar;
        act_ain_t smp;
        logic [9:0] result;
        logic cal_run;
        logic [13:0] cal_cnt;
        logic [1:0] istat;
        logic [1:0] imask;
        logic irq;
        logic busy;
        logic samp_out;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } act_st_t;
endpackage

// File: hw/act_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module act_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // raw and filtered value
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } act_sync_st_t;

    act_sync_st_t st_ff;
    act_sync_st_t nxt_st;
    logic [W-1:0] differ;

    // s1 feeds only s2; a bit moves on once s2 and s3 agree
    always_comb
    begin
        differ = st_ff.s2 ^ st_ff.s3;
        nxt_st = st_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        nxt_st.q = (st_ff.s2 & ~differ) | (st_ff.q & differ);
    end

    // state register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.q;
endmodule

// File: hw/act_bc_div.sv
// basic conversion clock divider counting system ticks
`timescale 1ns/10ps
module act_bc_div #(
    parameter int W = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // system tick, realignment and ratio
    input wire logic sys_tick,
    input wire logic restart,
    input wire logic [W-1:0] divisor,
    // one-cycle pulse per basic period
    output logic bc_tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } act_div_st_t;

    act_div_st_t st_ff;
    act_div_st_t nxt_st;
    logic fire;
    logic [W-1:0] gap_ff;
    logic ok_ff;

    // restart realigns the period so a conversion sees whole basic periods
    always_comb
    begin
        fire = sys_tick && (st_ff.cnt == divisor - W'(1));
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (restart)
        begin
            nxt_st.cnt = '0;
        end
        else if (fire)
        begin
            nxt_st.cnt = '0;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + W'(sys_tick);
        end
    end

    // state register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign bc_tick = st_ff.tick;

    // system ticks between two output pulses, counted apart from the divider itself
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            gap_ff <= '0;
            ok_ff <= 1'b0;
        end
        else
        begin
            gap_ff <= restart ? '0 : (st_ff.tick ? W'(sys_tick) : gap_ff + W'(sys_tick));
            ok_ff <= (restart || st_ff.tick) ? 1'b1 : (ok_ff && $stable(divisor));
        end
    end

    chk_div_ratio: assert property (@(posedge clk) disable iff (reset)
        (bc_tick && ok_ff && $stable(divisor)) |-> (gap_ff == divisor))
        else $error("basic period does not match the divisor");
endmodule

// File: hw/act_conv_timing.sv
// conversion timing and sequencing of a successive approximation converter
`timescale 1ns/10ps
`include "act_map.svh"
// Notes on behaviour
// - The basic clock is the system clock divided by 4, 2, 16 or 8 for divider codes 0 to 3.
// - The sample phase lasts 8, 16, 32 or 64 basic periods for sample codes 0 to 3.
// - A 10-bit conversion with post-calibration takes 52 basic periods, sample, 6 system ticks.
// - Without post-calibration the 12-period calibration step is skipped, 40 periods at 10 bits.
// - An 8-bit conversion takes 44 basic periods with post-calibration or 32 without.
// - A conversion samples, then decides bit by bit, then loads the result register.
// - Input below ground gives all zeros, input above reference gives all ones.
// - After reset a calibration runs for 484 to 11696 basic periods, ending on a quiet reference or at the 11696 bound.
// - Conversions asked for during calibration run and push the calibration end out.
// - The divider table is the compatibility mode; an improved divider can be selected.
// - The converter runs on the system tick, at the rate of the CPU clock.
// - The CPU clock is the master clock or half of it, chosen by the halve select bit.
module act_conv_timing #(
    parameter logic [13:0] CAL_MIN_BC = `ACT_CAL_MIN_BC,
    parameter logic [13:0] CAL_MAX_BC = `ACT_CAL_MAX_BC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog front end pins
    input wire act_pkg::act_ain_t ain,
    // converter status outputs
    output logic sample_hold,
    output logic conv_busy,
    output logic irq
);
    import act_pkg::*;

    localparam act_st_t ST_RST = '{
        ctrl: `ACT_CTRL_RST,
        halve: `ACT_SYSCFG_RST,
        sys_ph: 1'b0,
        fsm: st_idle,
        cnt: 7'h00,
        bitn: 4'h0,
        sar: 10'h000,
        smp: '0,
        result: 10'h000,
        cal_run: 1'b1,
        cal_cnt: 14'h0000,
        istat: 2'h0,
        imask: `ACT_IMASK_RST,
        irq: 1'b0,
        busy: 1'b0,
        samp_out: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h00000000
    };

    act_st_t st_ff;
    act_st_t nxt_st;
    act_ain_t ain_q;
    logic bc_tick;
    logic sys_tick;
    logic access;
    logic wr;
    logic start_go;
    logic rd_err;
    logic [31:0] rd_mux;
    logic [4:0] divisor;
    logic [6:0] smp_bc;
    logic [3:0] lsb;
    logic [9:0] trial;
    logic [9:0] sat_val;
    logic [1:0] w1c;
    logic [1:0] set_ev;

    // pins come from outside the clock domain
    act_sync3 #(
        .W($bits(act_ain_t))
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .d(ain),
        .q(ain_q)
    );

    act_bc_div #(
        .W(5)
    ) u_div (
        .clk(clk),
        .reset(reset),
        .sys_tick(sys_tick),
        .restart(start_go),
        .divisor(divisor),
        .bc_tick(bc_tick)
    );

    // clk is the master clock; the system tick follows the cpu clock rate
    assign sys_tick = !st_ff.halve || st_ff.sys_ph;

    // divider ratio and sample length selection
    always_comb
    begin
        case (st_ff.ctrl.clk_div)
            2'h0: divisor = `ACT_DIV_C0;
            2'h1: divisor = `ACT_DIV_C1;
            2'h2: divisor = `ACT_DIV_C2;
            default: divisor = `ACT_DIV_C3;
        endcase
        if (st_ff.ctrl.improved)
        begin
            divisor = {1'b0, st_ff.ctrl.imp_div} + 5'h01;
        end
        case (st_ff.ctrl.smp_len)
            2'h0: smp_bc = `ACT_SMP_C0;
            2'h1: smp_bc = `ACT_SMP_C1;
            2'h2: smp_bc = `ACT_SMP_C2;
            default: smp_bc = `ACT_SMP_C3;
        endcase
    end

    // decision helpers and saturation value
    assign lsb = st_ff.ctrl.eight ? `ACT_LSB_8 : `ACT_LSB_10;
    assign trial = st_ff.sar | (10'h001 << st_ff.bitn);
    always_comb
    begin
        if (st_ff.smp.below)
        begin
            sat_val = `ACT_RES_LOW;
        end
        else if (st_ff.smp.above)
        begin
            sat_val = st_ff.ctrl.eight ? `ACT_RES_HIGH8 : `ACT_RES_HIGH10;
        end
        else
        begin
            sat_val = st_ff.ctrl.eight ? {2'h0, st_ff.sar[9:2]} : st_ff.sar;
        end
    end

    // register read decode; unmapped addresses answer with pslverr
    always_comb
    begin
        rd_err = 1'b0;
        case (paddr)
            `ACT_OFS_CTRL: rd_mux = {16'h0000, st_ff.ctrl[15:1], 1'b0};
            `ACT_OFS_STAT: rd_mux = {29'h00000000, st_ff.samp_out, st_ff.cal_run, st_ff.busy};
            `ACT_OFS_RESULT: rd_mux = {22'h000000, st_ff.result};
            `ACT_OFS_ISTAT: rd_mux = {30'h00000000, st_ff.istat};
            `ACT_OFS_IMASK: rd_mux = {30'h00000000, st_ff.imask};
            `ACT_OFS_SYSCFG: rd_mux = {31'h00000000, st_ff.halve};
            default:
            begin
                rd_mux = 32'h00000000;
                rd_err = 1'b1;
            end
        endcase
    end

    // writes land at the edge where the master sees pready high
    assign access = psel && penable;
    assign wr = access && st_ff.pready && pwrite && !rd_err;
    assign start_go = wr && (paddr == `ACT_OFS_CTRL) && pwdata[0] && (st_ff.fsm == st_idle);

    // next state of registers, sequencer and calibration
    always_comb
    begin
        nxt_st = st_ff;
        w1c = 2'h0;
        set_ev = 2'h0;
        nxt_st.sys_ph = st_ff.halve ? !st_ff.sys_ph : 1'b0;
        nxt_st.pready = access && !st_ff.pready;
        if (access && !st_ff.pready)
        begin
            nxt_st.prdata = rd_mux;
            nxt_st.pslverr = rd_err;
        end
        if (wr)
        begin
            case (paddr)
                `ACT_OFS_CTRL: nxt_st.ctrl = act_ctrl_t'(pwdata[15:0] & `ACT_CTRL_WMASK);
                `ACT_OFS_ISTAT: w1c = pwdata[1:0];
                `ACT_OFS_IMASK: nxt_st.imask = pwdata[1:0];
                `ACT_OFS_SYSCFG: nxt_st.halve = pwdata[0];
                default: nxt_st.halve = st_ff.halve;
            endcase
        end
        case (st_ff.fsm)
            st_idle:
            begin
                if (start_go)
                begin
                    nxt_st.fsm = st_sample;
                    nxt_st.cnt = 7'h00;
                    nxt_st.samp_out = 1'b1;
                end
                else if (st_ff.cal_run && bc_tick)
                begin
                    // calibration only advances while no conversion runs
                    if ((st_ff.cal_cnt >= CAL_MIN_BC - 14'h0001 && ain_q.quiet) ||
                        st_ff.cal_cnt == CAL_MAX_BC - 14'h0001)
                    begin
                        nxt_st.cal_run = 1'b0;
                        set_ev[`ACT_IRQ_CAL] = 1'b1;
                    end
                    else
                    begin
                        nxt_st.cal_cnt = st_ff.cal_cnt + 14'h0001;
                    end
                end
            end
            st_sample:
            begin
                if (bc_tick)
                begin
                    if (st_ff.cnt == smp_bc - 7'h01)
                    begin
                        nxt_st.fsm = st_decide;
                        nxt_st.smp = ain_q;
                        nxt_st.samp_out = 1'b0;
                        nxt_st.cnt = 7'h00;
                        nxt_st.bitn = `ACT_TOP_BIT;
                        nxt_st.sar = 10'h000;
                    end
                    else
                    begin
                        nxt_st.cnt = st_ff.cnt + 7'h01;
                    end
                end
            end
            st_decide:
            begin
                if (bc_tick)
                begin
                    if (st_ff.cnt == `ACT_BIT_BC - 7'h01)
                    begin
                        nxt_st.cnt = 7'h00;
                        if (trial <= st_ff.smp.level)
                        begin
                            nxt_st.sar = trial;
                        end
                        if (st_ff.bitn == lsb)
                        begin
                            nxt_st.fsm = st_ff.ctrl.postcal ? st_postcal : st_load;
                        end
                        else
                        begin
                            nxt_st.bitn = st_ff.bitn - 4'h1;
                        end
                    end
                    else
                    begin
                        nxt_st.cnt = st_ff.cnt + 7'h01;
                    end
                end
            end
            st_postcal:
            begin
                if (bc_tick)
                begin
                    if (st_ff.cnt == `ACT_POSTCAL_BC - 7'h01)
                    begin
                        nxt_st.fsm = st_load;
                        nxt_st.cnt = 7'h00;
                    end
                    else
                    begin
                        nxt_st.cnt = st_ff.cnt + 7'h01;
                    end
                end
            end
            st_load:
            begin
                // load runs on system ticks, not basic periods
                if (sys_tick)
                begin
                    if (st_ff.cnt == `ACT_LOAD_SYS - 7'h01)
                    begin
                        nxt_st.fsm = st_idle;
                        nxt_st.result = sat_val;
                        nxt_st.cnt = 7'h00;
                        set_ev[`ACT_IRQ_DONE] = 1'b1;
                    end
                    else
                    begin
                        nxt_st.cnt = st_ff.cnt + 7'h01;
                    end
                end
            end
            default: nxt_st.fsm = st_idle;
        endcase
        // a new event beats a clear in the same cycle
        nxt_st.istat = (st_ff.istat & ~w1c) | set_ev;
        nxt_st.irq = |(nxt_st.istat & nxt_st.imask);
        nxt_st.busy = (nxt_st.fsm != st_idle);
    end

    // state register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_ff <= ST_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign sample_hold = st_ff.samp_out;
    assign conv_busy = st_ff.busy;
    assign irq = st_ff.irq;

    // basic periods seen in the sample and decision phases
    logic [6:0] smp_seen_ff;
    logic [6:0] dec_seen_ff;
    logic [6:0] dec_want;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            smp_seen_ff <= 7'h00;
            dec_seen_ff <= 7'h00;
        end
        else
        begin
            smp_seen_ff <= start_go ? 7'h00 : smp_seen_ff +
                7'((st_ff.fsm == st_sample) && bc_tick);
            dec_seen_ff <= start_go ? 7'h00 : dec_seen_ff +
                7'((st_ff.fsm == st_decide || st_ff.fsm == st_postcal) && bc_tick);
        end
    end
    assign dec_want = st_ff.ctrl.eight ?
        (st_ff.ctrl.postcal ? `ACT_CONV8P_BC : `ACT_CONV8_BC) :
        (st_ff.ctrl.postcal ? `ACT_CONV10P_BC : `ACT_CONV10_BC);

    chk_sample_len: assert property (@(posedge clk) disable iff (reset)
        (st_ff.fsm == st_sample && nxt_st.fsm == st_decide) |-> (smp_seen_ff + 7'h01 == smp_bc))
        else $error("sample phase length wrong");
    chk_decide_len: assert property (@(posedge clk) disable iff (reset)
        (st_ff.fsm != st_load && nxt_st.fsm == st_load) |-> (dec_seen_ff + 7'h01 == dec_want))
        else $error("decision phase length wrong");
    chk_load_len: assert property (@(posedge clk) disable iff (reset)
        ($rose(st_ff.fsm == st_load) && !st_ff.halve && $stable(st_ff.halve)) |->
        (st_ff.fsm == st_load)[*6] ##1 (st_ff.fsm == st_idle))
        else $error("load phase not six system ticks");
    chk_phase_order: assert property (@(posedge clk) disable iff (reset)
        $rose(st_ff.fsm == st_decide) |-> ($past(st_ff.fsm) == st_sample && !st_ff.samp_out))
        else $error("decision did not follow sampling");
    chk_sat_low: assert property (@(posedge clk) disable iff (reset)
        (st_ff.fsm == st_load && nxt_st.fsm == st_idle && st_ff.smp.below) |=>
        (st_ff.result == `ACT_RES_LOW))
        else $error("below ground result not zero");
    chk_sat_high: assert property (@(posedge clk) disable iff (reset)
        (st_ff.fsm == st_load && nxt_st.fsm == st_idle && st_ff.smp.above &&
        !st_ff.smp.below && !st_ff.ctrl.eight) |=> (st_ff.result == `ACT_RES_HIGH10))
        else $error("above reference result not full scale");
    chk_cal_min: assert property (@(posedge clk) disable iff (reset)
        $fell(st_ff.cal_run) |-> ($past(st_ff.cal_cnt) >= CAL_MIN_BC - 14'h0001))
        else $error("calibration ended too early");
    chk_cal_pause: assert property (@(posedge clk) disable iff (reset)
        (st_ff.cal_run && st_ff.fsm != st_idle) |=> $stable(st_ff.cal_cnt))
        else $error("calibration advanced during a conversion");
    chk_done_flag: assert property (@(posedge clk) disable iff (reset)
        (st_ff.fsm == st_load && nxt_st.fsm == st_idle) |=>
        (st_ff.istat[`ACT_IRQ_DONE] ##1 st_ff.fsm == st_idle))
        else $error("completion flag not raised");
    chk_irq_level: assert property (@(posedge clk) disable iff (reset)
        (((set_ev & st_ff.imask) != 2'h0) && !wr) |=> irq)
        else $error("unmasked event did not raise the interrupt");
    chk_apb_answer: assert property (@(posedge clk) disable iff (reset)
        (psel && penable) |-> ##[0:1] pready)
        else $error("apb access not answered");
endmodule

// File: verification/act_ain_model.sv
// behavioural analog front end driving the converter input pins
`timescale 1ns/10ps
module act_ain_model (
    // requested input in lsb steps and reference noise state
    input wire logic signed [11:0] volts,
    input wire logic noise_low,
    // converter pins
    output act_pkg::act_ain_t ain
);
    import act_pkg::*;
    // flag overdrive on either side; level keeps moving so it is never trusted there
    always_comb
    begin
        ain.quiet = noise_low;
        ain.below = volts < 0;
        ain.above = volts > 12'sd1023;
        ain.level = volts[9:0];
    end
endmodule

// File: verification/test_adc_conversion_timing.sv
// register level testbench of the converter timing block
`timescale 1ns/10ps
module test_adc_conversion_timing;
    import act_pkg::*;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, rerr;
    logic sample_hold, conv_busy, irq, noise_low;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic signed [11:0] volts;
    act_ain_t ain;
    int num_errors = 0;
    int total_checks = 0;
    int i;
    int dv[4] = '{4, 2, 16, 8};
    int sl[4] = '{8, 16, 32, 64};
    int dd[4] = '{52, 44, 40, 32};

    // short calibration bounds keep the run brief
    act_conv_timing #(.CAL_MIN_BC(14'h0004), .CAL_MAX_BC(14'h0014)) i_act_conv_timing (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ain(ain), .sample_hold(sample_hold),
        .conv_busy(conv_busy), .irq(irq));
    act_ain_model i_act_ain_model (.volts(volts), .noise_low(noise_low), .ain(ain));

    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            num_errors++;
            print_verdict();
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // start a conversion; time it and its sample phase in clocks
    task automatic conv(input logic [15:0] c, input int s, input int d, input int v, input int h);
        int n;
        int ns;
        int e;
        e = (s + d) * v * h + 6 * h;
        n = 0;
        ns = 0;
        apb(1'b1, 8'h00, {16'h0000, c | 16'h0001});
        do
        begin
            @(posedge clk);
            n++;
            if (sample_hold === 1'b1)
                ns++;
        end
        while ((n < 3 || conv_busy !== 1'b0) && n < 20000);
        check((n >= e && n <= e + 4) ? e : n, e);
        check((ns >= s * v * h - 2 && ns <= s * v * h + 2) ? s * v * h : ns, s * v * h);
        if (n >= 20000)
            print_verdict();
    endtask

    // poll until reset calibration is over
    task automatic wait_cal();
        for (int n = 0; n < 100; n++)
        begin
            apb(1'b0, 8'h04, 32'h0);
            if (rd[1] === 1'b0)
                break;
        end
        check(rd[1], 1'b0);
        if (rd[1] !== 1'b0)
            print_verdict();
    endtask

    // main sequence
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        volts = 12'sh2A5;
        noise_low = 1'b0;
        reset = 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rchk(8'h00, 32'h0004);
        rchk(8'h04, 32'h0002);
        rchk(8'h10, 32'h0);
        rchk(8'h14, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        check({rd[31:1], rerr}, 32'h1);
        conv(16'h4004, 8, 52, 2, 1);
        rchk(8'h04, 32'h0002);
        rchk(8'h08, 32'h02A5);
        wait_cal();
        rchk(8'h0C, 32'h3);
        apb(1'b1, 8'h0C, 32'h3);
        rchk(8'h0C, 32'h0);
        // basic clock rates stay inside 0.5 to 20 MHz here
        for (i = 0; i < 4; i++)
            conv({i[1:0], 14'h0004}, 8, 52, dv[i], 1);
        for (i = 0; i < 4; i++)
            conv({2'b01, i[1:0], 12'h004}, sl[i], 52, 2, 1);
        for (i = 0; i < 4; i++)
        begin
            conv({8'h40, 5'h00, ~i[1], i[0], 1'b0}, 8, dd[i], 2, 1);
            rchk(8'h08, i[0] ? 32'h00A9 : 32'h02A5);
        end
        volts <= -12'sd1;
        conv(16'h4004, 8, 52, 2, 1);
        rchk(8'h08, 32'h0);
        volts <= 12'sd1100;
        conv(16'h4004, 8, 52, 2, 1);
        rchk(8'h08, 32'h03FF);
        conv(16'h4006, 8, 44, 2, 1);
        rchk(8'h08, 32'h00FF);
        apb(1'b1, 8'h0C, 32'h3);
        apb(1'b1, 8'h10, 32'h1);
        conv(16'h4004, 8, 52, 2, 1);
        check(irq, 1'b1);
        apb(1'b1, 8'h0C, 32'h1);
        repeat (2) @(posedge clk);
        check(irq, 1'b0);
        apb(1'b1, 8'h10, 32'h0);
        conv(16'h4004, 8, 52, 2, 1);
        check(irq, 1'b0);
        rchk(8'h0C, 32'h1);
        apb(1'b1, 8'h14, 32'h1);
        conv(16'h4004, 8, 52, 2, 2);
        apb(1'b1, 8'h14, 32'h0);
        conv(16'h020C, 8, 52, 3, 1);
        noise_low <= 1'b1;
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rchk(8'h04, 32'h0002);
        wait_cal();
        print_verdict();
    end
endmodule
